/* File: design/mask_trig_pkg.sv */
// constants, field layout and types of the spectrum detector and mask trigger
package mask_trig_pkg;
	localparam int NUM_BINS = 1001;
	localparam int MIN_MASK_POINTS = 2;
	localparam int LEVEL_W = 16;
	localparam int ACC_W = 32;
	localparam int POINT_W = 10;
	localparam int LANES_DEFAULT = 4;
	localparam int FFT_CNT_W = 16;
	localparam longint CLOCK_HZ = 250000000;
	localparam int CLOCK_PERIOD_NS = 4;
	localparam longint CHECK_RATE = 600000;
	localparam int PULSE_TIME_US = 100;
	localparam int PULSE_CYCLES = (PULSE_TIME_US * 1000) / CLOCK_PERIOD_NS;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_MASK_PTR = 8'h0c;
	localparam logic [7:0] REG_MASK_DATA = 8'h10;
	localparam logic [7:0] REG_PRETRIG = 8'h14;
	localparam logic [7:0] REG_DWELL = 8'h18;
	localparam logic [7:0] REG_TRIG_COUNT = 8'h1c;
	// control, command, status, mask pointer, pretrigger and dwell fields
	localparam int CTRL_W = 10;
	localparam int CTRL_DET_LSB = 0;
	localparam int CTRL_UPPER_BIT = 2;
	localparam int CTRL_LOWER_BIT = 3;
	localparam int CTRL_LEAVE_BIT = 4;
	localparam int CTRL_MODE_LSB = 5;
	localparam int CTRL_TRIG_EN_BIT = 7;
	localparam int CTRL_SINGLE_BIT = 8;
	localparam int CTRL_SEQ_BIT = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h004;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int STAT_ARMED_BIT = 0;
	localparam int STAT_VIOL_BIT = 1;
	localparam int STAT_CAPTURE_BIT = 2;
	localparam int STAT_BINERR_BIT = 3;
	localparam int STAT_HELD_BIT = 4;
	localparam int MASK_SEL_BIT = 10;
	localparam int PRETRIG_W = 16;
	localparam int DWELL_W = 32;
	localparam logic [PRETRIG_W-1:0] PRETRIG_RESET = 16'h0000;
	localparam logic [DWELL_W-1:0] DWELL_RESET = 32'h0001_0000;
	typedef enum logic [1:0] {DET_POS_PEAK, DET_NEG_PEAK, DET_AVERAGE, DET_SAMPLE} detector_t;
	typedef enum logic [1:0] {MODE_AUTO_REARM, MODE_STOP, MODE_MARK_ONLY, MODE_SPARE} trig_mode_t;
endpackage

/* File: design/lane_store.sv */
// lane-wide storage array with per-lane write enables and combinational read
`timescale 1ns/1ns
module lane_store #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 251,
	parameter int LANES = 4,
	parameter int AW = 8
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [LANES-1:0] wr_lanes,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	localparam int LW = WIDTH / LANES;
	logic [WIDTH-1:0] mem [DEPTH];

	// one lane at a time for mask loading, all lanes for detector updates
	always_ff @(posedge clock)
	begin
		for (int l = 0; l < LANES; l++)
		begin
			if (wr_en && wr_lanes[l])
				mem[wr_addr][l*LW +: LW] <= wr_data[l*LW +: LW];
		end
	end

	assign rd_data = mem[rd_addr];
endmodule

/* File: design/spectrum_detector_mask_trigger.sv */
// sweep detector and frequency mask trigger with a wishbone register port
`timescale 1ns/1ns
module spectrum_detector_mask_trigger #(
	parameter int LANES = mask_trig_pkg::LANES_DEFAULT,
	parameter int PULSE_CYCLES = mask_trig_pkg::PULSE_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic fft_valid,
	input wire logic [LANES*mask_trig_pkg::LEVEL_W-1:0] fft_level,
	input wire logic fft_last,
	input wire logic fft_sweep_end,
	output logic det_valid,
	output logic [9:0] det_index,
	output logic [LANES*mask_trig_pkg::LEVEL_W-1:0] det_level,
	output logic det_last,
	output logic viol_valid,
	output logic viol_flag,
	output logic acq_start,
	output logic trig_out,
	output logic capture_active
);
	localparam int LW = mask_trig_pkg::LEVEL_W;
	localparam int AW = mask_trig_pkg::ACC_W;
	localparam int NB = mask_trig_pkg::NUM_BINS;
	localparam int BEATS = (NB + LANES - 1) / LANES;
	localparam int BW = $clog2(BEATS);
	localparam logic [BW-1:0] LAST_BEAT = BW'(BEATS - 1);
	localparam int CW = $clog2(PULSE_CYCLES + 1);

	// refuse lane counts that cannot keep pace or do not fit the index width
	if (LANES < 1 || LANES > 8)
		$error("LANES must lie in 1..8");
	if (mask_trig_pkg::CLOCK_HZ * LANES < mask_trig_pkg::CHECK_RATE * NB)
		$error("LANES too small for the mask check rate");
	if (PULSE_CYCLES < 1)
		$error("PULSE_CYCLES must be at least one");

	typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_ARMED, ST_HELD} arm_state_t;

	// byte-lane merge of a register write
	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	// a bin lies inside the mask area when the difference goes negative
	function automatic logic level_hit(input logic [LW-1:0] level, input logic [LW-1:0] mask,
		input logic lower);
		logic [LW:0] diff;
		if (lower)
			diff = {level[LW-1], level} - {mask[LW-1], mask};
		else
			diff = {mask[LW-1], mask} - {level[LW-1], level};
		return diff[LW];
	endfunction

	// fold one FFT value into a bin's running detector value
	function automatic logic [AW-1:0] det_combine(input mask_trig_pkg::detector_t sel,
		input logic first, input logic [AW-1:0] acc, input logic [LW-1:0] level);
		logic [AW-1:0] lv;
		lv = {{(AW-LW){level[LW-1]}}, level};
		if (first)
			return lv;
		case (sel)
			mask_trig_pkg::DET_POS_PEAK: return ($signed(lv) > $signed(acc)) ? lv : acc;
			mask_trig_pkg::DET_NEG_PEAK: return ($signed(lv) < $signed(acc)) ? lv : acc;
			mask_trig_pkg::DET_AVERAGE: return acc + lv;
			default: return acc;
		endcase
	endfunction

	logic [mask_trig_pkg::CTRL_W-1:0] ctrl_q;
	logic [10:0] mask_ptr_q;
	logic [mask_trig_pkg::PRETRIG_W-1:0] pretrig_q;
	logic [mask_trig_pkg::DWELL_W-1:0] dwell_q;
	logic [31:0] trig_count_q;
	logic wb_ack_q;
	logic [31:0] wb_dat_r_q;
	logic bin_err_q;
	logic [BW-1:0] beat_q;
	logic run_viol_q;
	logic prev_viol_q;
	logic viol_valid_q;
	logic viol_flag_q;
	arm_state_t state_q;
	logic [mask_trig_pkg::PRETRIG_W-1:0] pre_cnt_q;
	logic [mask_trig_pkg::FFT_CNT_W-1:0] fft_cnt_q;
	logic det_valid_q;
	logic [9:0] det_index_q;
	logic [LANES*LW-1:0] det_level_q;
	logic det_last_q;
	logic acq_start_q;
	logic trig_out_q;
	logic [CW-1:0] pulse_cnt_q;
	logic capture_q;
	logic [mask_trig_pkg::DWELL_W-1:0] dwell_cnt_q;

	mask_trig_pkg::detector_t det_sel;
	mask_trig_pkg::trig_mode_t mode;
	logic upper_en, lower_en, leave, trig_en;
	assign det_sel = mask_trig_pkg::detector_t'(ctrl_q[mask_trig_pkg::CTRL_DET_LSB +: 2]);
	assign mode = mask_trig_pkg::trig_mode_t'(ctrl_q[mask_trig_pkg::CTRL_MODE_LSB +: 2]);
	assign upper_en = ctrl_q[mask_trig_pkg::CTRL_UPPER_BIT];
	assign lower_en = ctrl_q[mask_trig_pkg::CTRL_LOWER_BIT];
	assign leave = ctrl_q[mask_trig_pkg::CTRL_LEAVE_BIT];
	assign trig_en = ctrl_q[mask_trig_pkg::CTRL_TRIG_EN_BIT];

	// bus request decode; a request is taken once, the cycle before ack
	logic bus_req, bus_wr;
	logic start_cmd, stop_cmd;
	assign bus_req = wb_cyc & wb_stb & ~wb_ack_q;
	assign bus_wr = bus_req & wb_we;
	assign start_cmd = bus_wr & (wb_adr == mask_trig_pkg::REG_CMD) & wb_sel[0]
		& wb_dat_w[mask_trig_pkg::CMD_START_BIT];
	assign stop_cmd = bus_wr & (wb_adr == mask_trig_pkg::REG_CMD) & wb_sel[0]
		& wb_dat_w[mask_trig_pkg::CMD_STOP_BIT];

	// mask point write: one point per word, pointer auto-increments
	logic mask_wr;
	logic [9:0] pidx;
	logic [BW-1:0] mask_wr_addr;
	logic [LANES-1:0] mask_wr_lanes;
	assign pidx = mask_ptr_q[9:0];
	assign mask_wr = bus_wr & (wb_adr == mask_trig_pkg::REG_MASK_DATA)
		& (int'(pidx) < NB);
	assign mask_wr_addr = BW'(int'(pidx) / LANES);
	assign mask_wr_lanes = LANES'(1 << (int'(pidx) % LANES));

	// software-written configuration registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl_q <= mask_trig_pkg::CTRL_RESET;
			mask_ptr_q <= 11'h000;
			pretrig_q <= mask_trig_pkg::PRETRIG_RESET;
			dwell_q <= mask_trig_pkg::DWELL_RESET;
		end
		else if (bus_wr)
		begin
			case (wb_adr)
				mask_trig_pkg::REG_CTRL:
					ctrl_q <= mask_trig_pkg::CTRL_W'(merge_sel(32'(ctrl_q), wb_dat_w, wb_sel));
				mask_trig_pkg::REG_MASK_PTR:
					mask_ptr_q <= 11'(merge_sel(32'(mask_ptr_q), wb_dat_w, wb_sel));
				mask_trig_pkg::REG_MASK_DATA:
					if (int'(pidx) < NB)
						mask_ptr_q <= mask_ptr_q + 11'h001;
				mask_trig_pkg::REG_PRETRIG:
					pretrig_q <= mask_trig_pkg::PRETRIG_W'(merge_sel(32'(pretrig_q), wb_dat_w,
						wb_sel));
				mask_trig_pkg::REG_DWELL:
					dwell_q <= merge_sel(dwell_q, wb_dat_w, wb_sel);
				default:
					ctrl_q <= ctrl_q;
			endcase
		end
	end

	// read mux; unmapped offsets answer zero
	logic [31:0] rd_word;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (wb_adr)
			mask_trig_pkg::REG_CTRL: rd_word = 32'(ctrl_q);
			mask_trig_pkg::REG_STATUS:
			begin
				rd_word[mask_trig_pkg::STAT_ARMED_BIT] = (state_q == ST_ARMED);
				rd_word[mask_trig_pkg::STAT_VIOL_BIT] = prev_viol_q;
				rd_word[mask_trig_pkg::STAT_CAPTURE_BIT] = capture_q;
				rd_word[mask_trig_pkg::STAT_BINERR_BIT] = bin_err_q;
				rd_word[mask_trig_pkg::STAT_HELD_BIT] = (state_q == ST_HELD);
			end
			mask_trig_pkg::REG_MASK_PTR: rd_word = 32'(mask_ptr_q);
			mask_trig_pkg::REG_PRETRIG: rd_word = 32'(pretrig_q);
			mask_trig_pkg::REG_DWELL: rd_word = dwell_q;
			mask_trig_pkg::REG_TRIG_COUNT: rd_word = trig_count_q;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// single-wait-state acknowledge with registered read data
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wb_ack_q <= 1'b0;
			wb_dat_r_q <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_q <= bus_req;
			wb_dat_r_q <= (bus_req & ~wb_we) ? rd_word : 32'h0000_0000;
		end
	end

	// mask tables and detector accumulators
	logic [LANES*LW-1:0] upper_rd, lower_rd;
	logic [LANES*AW-1:0] acc_rd, acc_new;
	lane_store #(.WIDTH(LANES*LW), .DEPTH(BEATS), .LANES(LANES), .AW(BW)) u_upper (
		.clock(clock),
		.wr_en(mask_wr & ~mask_ptr_q[mask_trig_pkg::MASK_SEL_BIT]),
		.wr_lanes(mask_wr_lanes),
		.wr_addr(mask_wr_addr),
		.wr_data({LANES{wb_dat_w[LW-1:0]}}),
		.rd_addr(beat_q),
		.rd_data(upper_rd)
	);
	lane_store #(.WIDTH(LANES*LW), .DEPTH(BEATS), .LANES(LANES), .AW(BW)) u_lower (
		.clock(clock),
		.wr_en(mask_wr & mask_ptr_q[mask_trig_pkg::MASK_SEL_BIT]),
		.wr_lanes(mask_wr_lanes),
		.wr_addr(mask_wr_addr),
		.wr_data({LANES{wb_dat_w[LW-1:0]}}),
		.rd_addr(beat_q),
		.rd_data(lower_rd)
	);
	lane_store #(.WIDTH(LANES*AW), .DEPTH(BEATS), .LANES(LANES), .AW(BW)) u_acc (
		.clock(clock),
		.wr_en(fft_valid),
		.wr_lanes({LANES{1'b1}}),
		.wr_addr(beat_q),
		.wr_data(acc_new),
		.rd_addr(beat_q),
		.rd_data(acc_rd)
	);

	// per-beat mask check over all bins that exist; padding lanes skipped
	logic beat_hit;
	always_comb
	begin
		beat_hit = 1'b0;
		for (int l = 0; l < LANES; l++)
		begin
			if (int'(beat_q) * LANES + l < NB)
			begin
				if (upper_en && level_hit(fft_level[l*LW +: LW], upper_rd[l*LW +: LW], 1'b0))
					beat_hit = 1'b1;
				if (lower_en && level_hit(fft_level[l*LW +: LW], lower_rd[l*LW +: LW], 1'b1))
					beat_hit = 1'b1;
			end
		end
	end

	logic spec_done, spec_viol, cond_met, fire;
	assign spec_done = fft_valid & fft_last;
	assign spec_viol = run_viol_q | beat_hit;
	assign cond_met = leave ? (prev_viol_q & ~spec_viol) : (~prev_viol_q & spec_viol);
	assign fire = spec_done & trig_en & (state_q == ST_ARMED) & cond_met;

	// bin position within a spectrum; length mismatches latch an error
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			beat_q <= '0;
			bin_err_q <= 1'b0;
		end
		else
		begin
			if (fft_valid)
				beat_q <= (fft_last || beat_q == LAST_BEAT) ? '0 : beat_q + 1'b1;
			bin_err_q <= (fft_valid & (fft_last ? (beat_q != LAST_BEAT) : (beat_q == LAST_BEAT)))
				| (bin_err_q & ~(bus_wr & (wb_adr == mask_trig_pkg::REG_STATUS) & wb_sel[0]
				& wb_dat_w[mask_trig_pkg::STAT_BINERR_BIT]));
		end
	end

	// per-spectrum violation, checked on every spectrum, no stall path
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			run_viol_q <= 1'b0;
			prev_viol_q <= 1'b0;
			viol_valid_q <= 1'b0;
			viol_flag_q <= 1'b0;
		end
		else
		begin
			run_viol_q <= spec_done ? 1'b0 : (fft_valid ? spec_viol : run_viol_q);
			if (spec_done)
				prev_viol_q <= spec_viol;
			viol_valid_q <= spec_done;
			if (spec_done)
				viol_flag_q <= spec_viol;
		end
	end

	// arming: pretrigger wait in stop mode, hold after the first stop trigger
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			pre_cnt_q <= '0;
		end
		else if (stop_cmd)
			state_q <= ST_IDLE;
		else if (start_cmd)
		begin
			pre_cnt_q <= pretrig_q;
			state_q <= (mode == mask_trig_pkg::MODE_STOP && pretrig_q != '0) ? ST_PRE : ST_ARMED;
		end
		else
		begin
			case (state_q)
				ST_PRE:
					if (spec_done)
					begin
						pre_cnt_q <= pre_cnt_q - 1'b1;
						if (pre_cnt_q == 1)
							state_q <= ST_ARMED;
					end
				ST_ARMED:
					if (fire && mode == mask_trig_pkg::MODE_STOP)
						state_q <= ST_HELD;
				ST_IDLE, ST_HELD:
					state_q <= state_q;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// detector: fold each FFT into its bins, emit on the sweep's last FFT
	always_comb
	begin
		acc_new = '0;
		for (int l = 0; l < LANES; l++)
			acc_new[l*AW +: AW] = det_combine(det_sel, fft_cnt_q == '0, acc_rd[l*AW +: AW],
				fft_level[l*LW +: LW]);
	end

	logic [AW-1:0] n_fft;
	assign n_fft = AW'(fft_cnt_q) + 1'b1;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			fft_cnt_q <= '0;
			det_valid_q <= 1'b0;
			det_index_q <= 10'h000;
			det_level_q <= '0;
			det_last_q <= 1'b0;
		end
		else
		begin
			if (spec_done)
				fft_cnt_q <= fft_sweep_end ? '0 : (&fft_cnt_q ? fft_cnt_q : fft_cnt_q + 1'b1);
			det_valid_q <= fft_valid & fft_sweep_end;
			det_last_q <= spec_done & fft_sweep_end;
			if (fft_valid)
			begin
				det_index_q <= 10'(beat_q);
				for (int l = 0; l < LANES; l++)
					det_level_q[l*LW +: LW] <= (det_sel == mask_trig_pkg::DET_AVERAGE)
						? LW'($signed(acc_new[l*AW +: AW]) / $signed(n_fft))
						: acc_new[l*AW +: LW];
			end
		end
	end

	// trigger output pulse and acquisition start
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			acq_start_q <= 1'b0;
			trig_out_q <= 1'b0;
			pulse_cnt_q <= '0;
			trig_count_q <= 32'h0000_0000;
		end
		else
		begin
			acq_start_q <= fire & (mode != mask_trig_pkg::MODE_MARK_ONLY);
			if (fire)
			begin
				trig_out_q <= 1'b1;
				pulse_cnt_q <= CW'(PULSE_CYCLES - 1);
				trig_count_q <= trig_count_q + 1'b1;
			end
			else if (pulse_cnt_q != '0)
				pulse_cnt_q <= pulse_cnt_q - 1'b1;
			else
				trig_out_q <= 1'b0;
		end
	end

	// capture window: dwell limit only for untriggered single or sequenced runs
	logic dwell_applies;
	assign dwell_applies = (ctrl_q[mask_trig_pkg::CTRL_SINGLE_BIT]
		| ctrl_q[mask_trig_pkg::CTRL_SEQ_BIT]) & ~trig_en;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			capture_q <= 1'b0;
			dwell_cnt_q <= '0;
		end
		else if (stop_cmd)
			capture_q <= 1'b0;
		else if (start_cmd)
		begin
			capture_q <= 1'b1;
			dwell_cnt_q <= '0;
		end
		else if (capture_q && dwell_applies)
		begin
			if (dwell_cnt_q + 1'b1 >= dwell_q)
				capture_q <= 1'b0;
			else
				dwell_cnt_q <= dwell_cnt_q + 1'b1;
		end
	end

	assign wb_ack = wb_ack_q;
	assign wb_dat_r = wb_dat_r_q;
	assign det_valid = det_valid_q;
	assign det_index = det_index_q;
	assign det_level = det_level_q;
	assign det_last = det_last_q;
	assign viol_valid = viol_valid_q;
	assign viol_flag = viol_flag_q;
	assign acq_start = acq_start_q;
	assign trig_out = trig_out_q;
	assign capture_active = capture_q;

	a_reset_detector: assert property (@(posedge clock) disable iff (rst)
		$past(rst) |-> det_sel == mask_trig_pkg::DET_POS_PEAK && upper_en && !lower_en)
		else $error("detector or mask kind wrong after reset");
	a_enter_fires: assert property (@(posedge clock) disable iff (rst)
		spec_done && trig_en && state_q == ST_ARMED && !leave && !prev_viol_q && beat_hit
		|=> trig_out_q && trig_count_q == $past(trig_count_q) + 1)
		else $error("entering the mask did not fire");
	a_leave_fires: assert property (@(posedge clock) disable iff (rst)
		spec_done && trig_en && state_q == ST_ARMED && leave && prev_viol_q && !spec_viol
		|=> trig_out_q ##0 pulse_cnt_q == CW'(PULSE_CYCLES - 1))
		else $error("leaving the mask did not fire");
	a_pulse_ends: assert property (@(posedge clock) disable iff (rst)
		trig_out_q && pulse_cnt_q == '0 && !fire |=> !trig_out_q)
		else $error("trigger pulse longer than its width");
	a_pretrig_quiet: assert property (@(posedge clock) disable iff (rst)
		state_q == ST_PRE && spec_done |=> !acq_start_q && $stable(trig_count_q))
		else $error("trigger accepted during pretrigger");
	a_mark_no_acq: assert property (@(posedge clock) disable iff (rst)
		fire && mode == mask_trig_pkg::MODE_MARK_ONLY |=> !acq_start_q && trig_out_q)
		else $error("mark-only trigger touched acquisition");
	a_viol_kept: assert property (@(posedge clock) disable iff (rst)
		fft_valid && !fft_last && beat_hit ##1 fft_valid && fft_last |=> viol_flag_q)
		else $error("violation lost before spectrum end");
	a_stop_holds: assert property (@(posedge clock) disable iff (rst)
		fire && mode == mask_trig_pkg::MODE_STOP && !stop_cmd && !start_cmd
		|=> state_q == ST_HELD ##1 !fire)
		else $error("stop mode did not hold after trigger");
	a_dwell_ignored: assert property (@(posedge clock) disable iff (rst)
		capture_q && trig_en && !stop_cmd |=> capture_q)
		else $error("dwell limit ended a triggered capture");
	a_bin_count: assert property (@(posedge clock) disable iff (rst)
		fft_valid && fft_last && beat_q != LAST_BEAT |=> bin_err_q)
		else $error("short spectrum not flagged");
endmodule

/* File: dv/fft_source.sv */
// upstream fft engine model: flat spectra with one optional spike bin
`timescale 1ns/1ns
module fft_source (
	input wire logic clock,
	output logic fft_valid = 1'h0,
	output logic [63:0] fft_level = 64'h0,
	output logic fft_last = 1'h0,
	output logic fft_sweep_end = 1'h0
);
	// beats per spectrum; the bench shortens it to provoke a length error
	int beats = 251;
	// one spectrum; bins past 1000 carry a level the block must ignore
	task send(input logic [15:0] base, input int sb, input logic [15:0] sl, input logic se);
		int b, l;
		for (b = 0; b < beats; b++)
		begin
			@(posedge clock);
			fft_valid <= 1'h1;
			fft_last <= (b == beats - 1);
			fft_sweep_end <= se;
			for (l = 0; l < 4; l++)
				fft_level[l*16+:16] <= (b*4+l > 1000) ? 16'h7fff : (b*4+l == sb) ? sl : base;
		end
		@(posedge clock);
		fft_valid <= 1'h0;
		fft_last <= 1'h0;
		fft_sweep_end <= 1'h0;
		fft_level <= ~fft_level; // no stale data between spectra
	endtask
endmodule

/* File: dv/tb_spectrum_detector_mask_trigger.sv */
// bench for the spectrum detector and mask trigger
`timescale 1ns/1ns
module tb_spectrum_detector_mask_trigger;
	localparam int PC = 8;
	localparam logic [15:0] HI = 16'h0065, LO = 16'hff9b, Z = 16'h0000;
	logic clock = 1'h0, rst = 1'h1;
	logic wb_req = 1'h0, wb_we = 1'h0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'hf;
	logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rd;
	logic wb_ack, fft_valid, fft_last, fft_sweep_end, det_valid, det_last, viol_valid;
	logic viol_flag, acq_start, trig_out, capture_active, vflag;
	logic [63:0] fft_level, det_level;
	logic [9:0] det_index;
	logic [15:0] det0;
	int fail_count = 0, tests_run = 0, n_hi = 0, n_acq = 0, n_last = 0;
	// 250 MHz clock
	always #2 clock = ~clock;
	// upstream model and block under test
	fft_source src (.clock, .fft_valid, .fft_level, .fft_last, .fft_sweep_end);
	spectrum_detector_mask_trigger #(.LANES(4), .PULSE_CYCLES(PC)) dut (.clock, .rst,
		.wb_cyc(wb_req), .wb_stb(wb_req), .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r,
		.wb_ack, .fft_valid, .fft_level, .fft_last, .fft_sweep_end, .det_valid, .det_index,
		.det_level, .det_last, .viol_valid, .viol_flag, .acq_start, .trig_out, .capture_active);
	// latch spectrum verdicts and count trigger activity
	always @(posedge clock)
	begin
		if (viol_valid === 1'h1) vflag <= viol_flag;
		if (trig_out === 1'h1) n_hi <= n_hi + 1;
		if (acq_start === 1'h1) n_acq <= n_acq + 1;
		if (det_last === 1'h1) n_last <= n_last + 1;
		if (det_valid === 1'h1 && det_index === 10'h000) det0 <= det_level[15:0];
	end
	// compare and report
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	// verdict and end of run
	task complete_run(input int hung);
		fail_count += hung;
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one classic wishbone cycle; read data lands in rd
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		chk("wb_ack idle", 32'h0, {31'h0, wb_ack});
		wb_req <= 1'h1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		@(posedge clock);
		while (wb_ack !== 1'h1)
			@(posedge clock);
		rd = wb_dat_r;
		wb_req <= 1'h0;
	endtask
	// write control, then arm
	task cfg(input logic [31:0] c);
		wb(1'h1, mask_trig_pkg::REG_CTRL, c);
		wb(1'h1, mask_trig_pkg::REG_CMD, 32'h1);
	endtask
	// fill one mask with a flat level over all points
	task load(input logic lower, input logic [15:0] lvl);
		int i;
		wb(1'h1, mask_trig_pkg::REG_MASK_PTR, {21'h0, lower, 10'h000});
		for (i = 0; i < 1001; i++)
			wb(1'h1, mask_trig_pkg::REG_MASK_DATA, {16'h0, lvl});
	endtask
	// one spectrum, then its verdict, pulse width and acquisition starts
	task spec(input logic [15:0] sl, input int sb, input int ef, input int eh, input int ea);
		int h0, a0;
		h0 = n_hi;
		a0 = n_acq;
		src.send(Z, sb, sl, 1'h0);
		repeat (12) @(posedge clock);
		chk("viol_flag", ef, {31'h0, vflag});
		chk("trig_out cycles", eh, n_hi - h0);
		chk("acq_start pulses", ea, n_acq - a0);
	endtask
	// reset control value and an unmapped address
	task t_regs();
		wb(1'h0, mask_trig_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h0000_0004, rd);
		wb(1'h1, 8'h20, 32'hffff_ffff);
		wb(1'h0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask
	// upper mask entering: equal level, last bin, staying inside
	task t_enter();
		load(1'h0, 16'h0064);
		load(1'h1, 16'hff9c);
		cfg(32'h0000_0084);
		spec(Z, -1, 0, 0, 0);
		spec(16'h0064, 1000, 0, 0, 0);
		spec(HI, 1000, 1, PC, 1);
		spec(HI, 999, 1, 0, 0);
		spec(Z, -1, 0, 0, 0);
	endtask
	// lower mask leaving, then both masks entering
	task t_limits();
		cfg(32'h0000_0098);
		spec(16'hff9c, 0, 0, 0, 0);
		spec(LO, 0, 1, 0, 0);
		spec(HI, 5, 0, PC, 1);
		cfg(32'h0000_008c);
		spec(LO, 7, 1, PC, 1);
		spec(Z, -1, 0, 0, 0);
		spec(HI, 9, 1, PC, 1);
	endtask
	// mark only: pulse without acquisition start
	task t_mark();
		cfg(32'h0000_00c4);
		spec(Z, -1, 0, 0, 0);
		spec(HI, 2, 1, PC, 0);
	endtask
	// stop on trigger with one pretrigger spectrum, then held
	task t_stop();
		spec(Z, -1, 0, 0, 0);
		wb(1'h1, mask_trig_pkg::REG_PRETRIG, 32'h1);
		cfg(32'h0000_00a4);
		spec(HI, 4, 1, 0, 0);
		spec(Z, -1, 0, 0, 0);
		spec(HI, 4, 1, PC, 1);
		spec(Z, -1, 0, 0, 0);
		spec(HI, 4, 1, 0, 0);
	endtask
	// every detector over a sweep of two flat spectra, -6 then 9
	task t_det();
		logic [15:0] ev [4] = '{16'h0009, 16'hfffa, 16'h0001, 16'hfffa};
		int d, l0;
		for (d = 0; d < 4; d++)
		begin
			wb(1'h1, mask_trig_pkg::REG_CTRL, 32'h4 | d);
			l0 = n_last;
			src.send(Z, -1, Z, 1'h1);
			src.send(16'hfffa, -1, Z, 1'h0);
			src.send(16'h0009, -1, Z, 1'h1);
			repeat (4) @(posedge clock);
			chk("det_level bin 0", {16'h0, ev[d]}, {16'h0, det0});
			chk("det_last pulses", 32'h2, n_last - l0);
		end
	endtask
	// status after the held stop trigger, trigger count, short spectrum error
	task t_status();
		wb(1'h0, mask_trig_pkg::REG_STATUS, 32'h0);
		chk("status held", 32'h0000_0016, rd);
		wb(1'h0, mask_trig_pkg::REG_TRIG_COUNT, 32'h0);
		chk("trigger count", 32'h0000_0006, rd);
		src.beats = 9;
		src.send(Z, -1, Z, 1'h0);
		src.beats = 251;
		wb(1'h0, mask_trig_pkg::REG_STATUS, 32'h0);
		chk("status short spectrum", 32'h0000_001c, rd);
		wb(1'h1, mask_trig_pkg::REG_STATUS, 32'h8);
		wb(1'h0, mask_trig_pkg::REG_STATUS, 32'h0);
		chk("status cleared", 32'h0000_0014, rd);
	endtask
	// dwell ends an untriggered single run, not a triggered sequenced one; stop ends it
	task t_dwell();
		wb(1'h1, mask_trig_pkg::REG_DWELL, 32'h10);
		cfg(32'h0000_0104);
		repeat (30) @(posedge clock);
		chk("capture_active untriggered", 32'h0, {31'h0, capture_active});
		cfg(32'h0000_0284);
		repeat (30) @(posedge clock);
		chk("capture_active triggered", 32'h1, {31'h0, capture_active});
		wb(1'h1, mask_trig_pkg::REG_CMD, 32'h3);
		repeat (2) @(posedge clock);
		chk("capture_active stopped", 32'h0, {31'h0, capture_active});
	endtask
	// reset, scenarios, verdict
	initial
	begin
		repeat (20) @(posedge clock);
		rst <= 1'h0;
		t_regs();
		t_enter();
		t_limits();
		t_mark();
		t_stop();
		t_status();
		t_dwell();
		t_det();
		complete_run(0);
	end
	// hang guard, about 50000 cycles, far past the expected run
	initial #200000 complete_run(1);
endmodule
